// >>> src/dmaam_engine.sv
// DMA address-mode engine: dual and single address transfers on the shared bus
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: DMA addresses decode into regions whose alternate-master bit is clear.
// RULE2: DMA cycles time like core cycles; only transfer type and modifier differ.
// RULE3: Next transfer start follows the previous cycle's end with no idle clock.
// RULE4: Dual mode: source read phase first, then destination write phase.
// RULE5: Read and write counts follow size fields and addressed port widths.
// RULE6: Word read to byte destination is followed by two byte writes.
// RULE7: Destination larger than port on a bursting region is done as a burst.
// RULE8: Single mode makes exactly one access per transfer at the source address; the code splits it into port-width accesses on a narrower non-bursting port.
// RULE9: Single mode drives read/write from the programmed direction bit.
// RULE10: External logic decodes single-mode cycles for the second device.
// RULE11: Transfers touching the standby RAM are refused; code checks only the start source (and, in dual mode, destination) address.
// RULE12: DMA accesses take no cache coherency action.
// RULE13: Byte count drops by bytes moved; reaching zero sets the done flag.
// RULE14: Mastership is requested before cycles and returned after the job ends.
module dmaam_engine #(
	parameter int NREG = 2,
	parameter int BCW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Channel control
	input wire logic start,
	input wire logic done_clear,
	input wire logic single_mode,
	input wire logic single_rw,
	input wire logic src_inc,
	input wire logic dst_inc,
	input wire logic [1:0] source_size_field,
	input wire logic [1:0] dest_size_field,
	input wire logic [31:0] source_address_reg,
	input wire logic [31:0] dest_address_reg,
	input wire logic [BCW-1:0] byte_count_reg,
	// Region settings shared with the core
	input wire logic [NREG-1:0][31:0] region_base,
	input wire logic [NREG-1:0][31:0] region_mask,
	input wire logic [NREG-1:0][1:0] region_port,
	input wire logic [NREG-1:0][3:0] region_waits,
	input wire logic [NREG-1:0] region_burst,
	input wire logic [NREG-1:0] alternate_master_bit,
	input wire logic [31:0] sram_base,
	input wire logic [31:0] sram_mask,
	// External bus
	input wire logic bus_bg,
	input wire logic [31:0] bus_rdata,
	output logic bus_br,
	output logic transfer_start_strobe,
	output logic [31:0] bus_addr,
	output logic bus_rw,
	output logic [1:0] bus_siz,
	output logic bus_burst,
	output logic [1:0] bus_tt,
	output logic [2:0] bus_tm,
	output logic [NREG-1:0] bus_cs,
	output logic [31:0] bus_wdata,
	// Channel status
	output logic busy,
	output logic done,
	output logic error,
	output logic [BCW-1:0] byte_count_left
);
	import dmaam_pkg::*;

	dmaam_state_e state_r;
	logic single_r, srw_r, sinc_r, dinc_r, wr_r;
	logic [1:0] ssz_r, dsz_r;
	logic [31:0] src_r, dst_r;
	logic [4:0] left_r, beat_r, beats_r;
	logic [3:0] off_r, waits_r;
	logic [BCW-1:0] count_r;
	logic [7:0] buf_r [BUF_DEPTH];
	logic br_r, strobe_r, cont_r, rw_r, burst_r, busy_r, done_r, err_r;
	logic [31:0] addr_r, wdata_r;
	logic [1:0] siz_r;
	logic [NREG-1:0] cs_r;
	logic tmr_ack, more_beats, xfer_end, la_new, cont, la_wr, la_burst, st_ok;
	logic [4:0] xfer_b, rem, la_left, la_size, la_beat, la_beats;
	logic [3:0] la_off, la_waits;
	logic [31:0] la_addr, src_nxt, dst_nxt, la_wd;
	logic [1:0] la_port;
	logic [NREG-1:0] la_sel;
	logic [BCW-1:0] count_nxt;
	logic la_sram, start_src_sram, start_dst_sram;
	logic la_burst_ok, la_cap;
	logic [3:0] la_rel;

	// Bytes per transfer: one source-size access in single mode, larger size in dual
	assign xfer_b = single_r ? sz_bytes(ssz_r) :
		((sz_bytes(ssz_r) > sz_bytes(dsz_r)) ? sz_bytes(ssz_r) : sz_bytes(dsz_r)); // [RULE5] [RULE8]
	assign rem = left_r - beat_r;
	assign more_beats = beats_r > ONE_BEAT;
	assign xfer_end = (state_r == ST_BEAT) && tmr_ack && !more_beats && (rem == '0)
		&& (wr_r || single_r);
	assign count_nxt = count_r - BCW'(xfer_b); // [RULE13]
	assign la_cap = (state_r == ST_BEAT) && tmr_ack && !wr_r && !single_r; // [RULE4]
	assign src_nxt = sinc_r ? (src_r + 32'(xfer_b)) : src_r;
	assign dst_nxt = dinc_r ? (dst_r + 32'(xfer_b)) : dst_r;

	// Look-ahead of the next beat, so its start strobe goes out on the edge after the ack
	always_comb
	begin
		la_new = 1'b0;
		cont = 1'b0;
		la_addr = addr_r + 32'(beat_r);
		la_wr = wr_r;
		la_left = rem;
		la_off = off_r + beat_r[3:0];
		if (state_r == ST_REQ)
		begin
			la_new = bus_bg; // [RULE14]
			la_addr = src_r;
			la_wr = 1'b0;
			la_left = xfer_b;
			la_off = '0;
		end
		else if (state_r == ST_BEAT && tmr_ack)
		begin
			if (more_beats)
				cont = 1'b1;
			else if (rem != '0)
				la_new = 1'b1; // [RULE3]
			else if (!wr_r && !single_r)
			begin
				// Read phase done: the write phase starts at the destination
				la_new = 1'b1; // [RULE4] [RULE6]
				la_addr = dst_r;
				la_wr = 1'b1;
				la_left = xfer_b;
				la_off = '0;
			end
			else if (count_nxt != '0)
			begin
				la_new = 1'b1; // [RULE3]
				la_addr = src_nxt;
				la_wr = 1'b0;
				la_left = xfer_b;
				la_off = '0;
			end
		end
	end

	// Beat shape from the size field and the addressed port
	assign la_size = la_wr ? sz_bytes(dsz_r) : sz_bytes(ssz_r);
	assign la_beat = beat_of(la_size, la_port); // [RULE5]
	assign la_burst = la_burst_ok && (la_beat < la_size); // [RULE7]
	assign la_beats = la_burst ? (la_size >> lg2(la_beat)) : ONE_BEAT;

	// Write data for the next beat, low lanes first; bytes read in this very cycle
	// reach the buffer only at the edge, so they are taken from the bus directly
	always_comb
	begin
		la_wd = '0;
		la_rel = '0;
		for (int i = 0; i < BUS_BYTES; i++)
		begin
			la_rel = la_off + 4'(i) - off_r;
			if (la_cap && (5'(la_rel) < beat_r))
				la_wd[i*8 +: 8] = bus_rdata[{la_rel[1:0], 3'h0} +: 8]; // [RULE6]
			else
				la_wd[i*8 +: 8] = buf_r[la_off + 4'(i)];
		end
	end

	// Next-beat decode and the start-time standby RAM check
	dmaam_region_dec #(.NREG(NREG)) u_la_dec (
		.addr(la_addr),
		.region_base(region_base),
		.region_mask(region_mask),
		.region_port(region_port),
		.region_waits(region_waits),
		.region_burst(region_burst),
		.alternate_master_bit(alternate_master_bit),
		.sram_base(sram_base),
		.sram_mask(sram_mask),
		.hit_sel(la_sel),
		.port(la_port),
		.waits(la_waits),
		.burst(la_burst_ok),
		.sram_hit(la_sram)
	);
	dmaam_region_dec #(.NREG(NREG)) u_dst_dec (
		.addr(dest_address_reg),
		.region_base(region_base),
		.region_mask(region_mask),
		.region_port(region_port),
		.region_waits(region_waits),
		.region_burst(region_burst),
		.alternate_master_bit(alternate_master_bit),
		.sram_base(sram_base),
		.sram_mask(sram_mask),
		.hit_sel(),
		.port(),
		.waits(),
		.burst(),
		.sram_hit(start_dst_sram)
	);
	// Source check sees the programmed address directly while idle
	assign start_src_sram = ((source_address_reg & sram_mask) == (sram_base & sram_mask));
	assign st_ok = !start_src_sram && (single_mode || !start_dst_sram); // [RULE11]

	dmaam_beat_timer #(.WW(4)) u_timer (
		.clk(clk),
		.rstn(rstn),
		.launch(strobe_r | cont_r),
		.waits(waits_r),
		.ack(tmr_ack)
	);

	// Channel sequencing and bus mastership
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= ST_IDLE;
			br_r <= 1'b0;
			busy_r <= 1'b0;
			err_r <= 1'b0;
			single_r <= 1'b0;
			srw_r <= 1'b0;
			sinc_r <= 1'b0;
			dinc_r <= 1'b0;
			ssz_r <= SZ_BYTE;
			dsz_r <= SZ_BYTE;
			src_r <= '0;
			dst_r <= '0;
			count_r <= '0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
					if (start)
					begin
						err_r <= !st_ok; // [RULE11]
						if (st_ok && byte_count_reg != '0)
						begin
							state_r <= ST_REQ;
							br_r <= 1'b1; // [RULE14]
							busy_r <= 1'b1;
						end
						single_r <= single_mode;
						srw_r <= single_rw;
						sinc_r <= src_inc;
						dinc_r <= dst_inc;
						ssz_r <= source_size_field;
						dsz_r <= dest_size_field;
						src_r <= source_address_reg;
						dst_r <= dest_address_reg;
						count_r <= byte_count_reg;
					end
				ST_REQ:
					if (bus_bg)
						state_r <= ST_BEAT;
				ST_BEAT:
					if (xfer_end)
					begin
						count_r <= count_nxt; // [RULE13]
						src_r <= src_nxt;
						dst_r <= dst_nxt;
						if (count_nxt == '0)
						begin
							state_r <= ST_IDLE;
							br_r <= 1'b0; // [RULE14]
							busy_r <= 1'b0;
						end
					end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Bus cycle outputs; no snoop or invalidate output exists, so caches stay untouched
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			strobe_r <= 1'b0;
			cont_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= '0;
			rw_r <= 1'b1;
			siz_r <= SZ_BYTE;
			burst_r <= 1'b0;
			cs_r <= '0;
			waits_r <= DEF_WAITS;
			wr_r <= 1'b0;
			left_r <= '0;
			off_r <= '0;
			beat_r <= ONE_BEAT;
			beats_r <= ONE_BEAT;
		end
		else
		begin
			strobe_r <= la_new; // [RULE3]
			cont_r <= cont;
			if (la_new || cont)
			begin
				addr_r <= la_addr;
				wdata_r <= la_wd;
				wr_r <= la_wr;
				left_r <= la_left;
				off_r <= la_off;
			end
			if (la_new)
			begin
				// Region timing and chip select are the core's own for that address
				cs_r <= la_sel; // [RULE1] [RULE2]
				waits_r <= la_waits;
				rw_r <= single_r ? srw_r : !la_wr; // [RULE9] [RULE12]
				siz_r <= la_burst ? code_of(la_size) : code_of(la_beat);
				burst_r <= la_burst; // [RULE7]
				beat_r <= la_beat;
				beats_r <= la_beats;
			end
			else if (cont)
				beats_r <= beats_r - ONE_BEAT;
			else if (xfer_end)
			begin
				cs_r <= '0;
				burst_r <= 1'b0;
			end
		end
	end

	// Read data lands in the staging buffer; single mode moves no data through here
	always_ff @(posedge clk)
	begin
		if (la_cap) // [RULE4]
			for (int i = 0; i < BUS_BYTES; i++)
				if (5'(i) < beat_r)
					buf_r[off_r + 4'(i)] <= bus_rdata[i*8 +: 8];
	end

	// Done is sticky; a completion in the cycle of a clear still wins
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			done_r <= 1'b0;
		else if (xfer_end && count_nxt == '0)
			done_r <= 1'b1; // [RULE13]
		else if (done_clear)
			done_r <= 1'b0;
	end

	assign bus_br = br_r;
	assign transfer_start_strobe = strobe_r;
	assign bus_addr = addr_r;
	assign bus_rw = rw_r;
	assign bus_siz = siz_r;
	assign bus_burst = burst_r;
	assign bus_tt = TT_DMA;
	assign bus_tm = single_r ? TM_SINGLE : TM_DUAL;
	assign bus_cs = cs_r;
	assign bus_wdata = wdata_r;
	assign busy = busy_r;
	assign done = done_r;
	assign error = err_r;
	assign byte_count_left = count_r;

	back_to_back_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE3]
		(state_r == ST_BEAT && tmr_ack && !more_beats && !(xfer_end && count_nxt == '0))
		|=> transfer_start_strobe)
		else $error("idle clock between DMA bus cycles");
	dma_type_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
		transfer_start_strobe |-> (bus_tt == TT_DMA && bus_br))
		else $error("DMA cycle without DMA transfer type");
	single_dir_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE9]
		(transfer_start_strobe && single_r) |-> (bus_rw == srw_r && bus_tm == TM_SINGLE))
		else $error("single address direction wrong");
	read_first_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE4]
		(state_r == ST_REQ && bus_bg && !single_r) |=> (transfer_start_strobe && bus_rw))
		else $error("dual transfer did not open with a read");
	sram_refuse_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE11]
		(state_r == ST_IDLE && start && start_src_sram) |=> (error && !busy && !bus_br))
		else $error("standby RAM transfer not refused");
	count_down_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE13]
		xfer_end |=> (byte_count_left == $past(count_r) - BCW'($past(xfer_b))))
		else $error("byte count not reduced by bytes moved");
	done_release_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE14]
		(xfer_end && count_nxt == '0) |=> (done && !bus_br && !busy) ##1 !transfer_start_strobe)
		else $error("completion did not set done and release bus");
	grant_held_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE14]
		$rose(bus_br) |-> !transfer_start_strobe)
		else $error("cycle started before mastership");
	burst_shape_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
		(transfer_start_strobe && bus_burst) |-> (beats_r > ONE_BEAT && beat_r < sz_bytes(bus_siz)))
		else $error("burst issued without oversize request");
	zero_wait_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE1]
		(transfer_start_strobe && waits_r == DEF_WAITS) |=> tmr_ack)
		else $error("zero wait beat not ended after one clock");
	word_to_byte_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
		(transfer_start_strobe && !single_r && bus_rw && ssz_r == SZ_WORD && dsz_r == SZ_BYTE
		&& beat_r == NB_WORD && waits_r == DEF_WAITS) |=> ##1 (transfer_start_strobe && !bus_rw))
		else $error("word read not followed by destination write");
endmodule // dmaam_engine
`default_nettype wire

// >>> pkg/dmaam_pkg.sv
// Shared constants, encodings and helper functions for the DMA address-mode engine
package dmaam_pkg;
	// Size encodings, used both for transfer sizes and for region port widths
	localparam logic [1:0] SZ_LONG = 2'h0;
	localparam logic [1:0] SZ_BYTE = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_LINE = 2'h3;
	// Byte counts of each size
	localparam logic [4:0] NB_BYTE = 5'h01;
	localparam logic [4:0] NB_WORD = 5'h02;
	localparam logic [4:0] NB_LONG = 5'h04;
	localparam logic [4:0] NB_LINE = 5'h10;
	localparam logic [4:0] ONE_BEAT = 5'h01;
	localparam int BUF_DEPTH = 16;
	localparam int BUS_BYTES = 4;
	// Transfer type and modifier: the only outputs that differ from a core cycle
	localparam logic [1:0] TT_DMA = 2'h1;
	localparam logic [2:0] TM_DUAL = 3'h1;
	localparam logic [2:0] TM_SINGLE = 3'h2;
	// Timing used when no region claims the address
	localparam logic [3:0] DEF_WAITS = 4'h0;
	localparam logic [1:0] DEF_PORT = SZ_LONG;

	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_BEAT} dmaam_state_e;

	// Bytes in a transfer size
	function automatic logic [4:0] sz_bytes(input logic [1:0] code);
		case (code)
			SZ_BYTE: sz_bytes = NB_BYTE;
			SZ_WORD: sz_bytes = NB_WORD;
			SZ_LINE: sz_bytes = NB_LINE;
			default: sz_bytes = NB_LONG;
		endcase
	endfunction

	// Bytes per beat: the smaller of request and port, never wider than the bus
	function automatic logic [4:0] beat_of(input logic [4:0] req, input logic [1:0] port);
		logic [4:0] pb;
		pb = (port == SZ_LINE) ? NB_LONG : sz_bytes(port);
		beat_of = (req < pb) ? req : pb;
	endfunction

	// Log2 of a power-of-two byte count
	function automatic logic [2:0] lg2(input logic [4:0] b);
		case (b)
			NB_WORD: lg2 = 3'h1;
			NB_LONG: lg2 = 3'h2;
			NB_LINE: lg2 = 3'h4;
			default: lg2 = 3'h0;
		endcase
	endfunction

	// Size code of a byte count
	function automatic logic [1:0] code_of(input logic [4:0] b);
		case (b)
			NB_BYTE: code_of = SZ_BYTE;
			NB_WORD: code_of = SZ_WORD;
			NB_LINE: code_of = SZ_LINE;
			default: code_of = SZ_LONG;
		endcase
	endfunction
endpackage

// >>> src/dmaam_region_dec.sv
// Address decoder: region match, port width, wait states, burst and standby RAM hit
`timescale 1ns/1ps
`default_nettype none
module dmaam_region_dec #(
	parameter int NREG = 2
) (
	// Address under test
	input wire logic [31:0] addr,
	// Region settings
	input wire logic [NREG-1:0][31:0] region_base,
	input wire logic [NREG-1:0][31:0] region_mask,
	input wire logic [NREG-1:0][1:0] region_port,
	input wire logic [NREG-1:0][3:0] region_waits,
	input wire logic [NREG-1:0] region_burst,
	input wire logic [NREG-1:0] alternate_master_bit,
	// On-chip standby RAM window
	input wire logic [31:0] sram_base,
	input wire logic [31:0] sram_mask,
	// Decode results
	output logic [NREG-1:0] hit_sel,
	output logic [1:0] port,
	output logic [3:0] waits,
	output logic burst,
	output logic sram_hit
);
	import dmaam_pkg::*;

	// Lowest-numbered region wins; a region set aside for alternate masters is skipped
	always_comb
	begin
		hit_sel = '0;
		port = DEF_PORT;
		waits = DEF_WAITS;
		burst = 1'b0;
		for (int i = NREG - 1; i >= 0; i--)
		begin
			if (!alternate_master_bit[i] && ((addr & region_mask[i]) == (region_base[i] & region_mask[i]))) // [RULE1]
			begin
				hit_sel = '0;
				hit_sel[i] = 1'b1;
				port = region_port[i];
				waits = region_waits[i];
				burst = region_burst[i];
			end
		end
	end

	// Standby RAM is not reachable from the external bus
	assign sram_hit = ((addr & sram_mask) == (sram_base & sram_mask));
endmodule // dmaam_region_dec
`default_nettype wire

// >>> src/dmaam_beat_timer.sv
// Beat timer: ends each bus beat after the region's wait states
`timescale 1ns/1ps
`default_nettype none
module dmaam_beat_timer #(
	parameter int WW = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Beat launch and its wait states
	input wire logic launch,
	input wire logic [WW-1:0] waits,
	// Beat end
	output logic ack
);
	logic busy_r;
	logic [WW-1:0] cnt_r;

	// Same count for core and DMA cycles, so the beat length is the region's own
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_r <= 1'b0;
			cnt_r <= '0;
		end
		else if (launch)
		begin
			busy_r <= 1'b1;
			cnt_r <= '0;
		end
		else if (ack)
			busy_r <= 1'b0;
		else if (busy_r)
			cnt_r <= cnt_r + 1'b1;
	end

	assign ack = busy_r && (cnt_r == waits); // [RULE2]
endmodule // dmaam_beat_timer
`default_nettype wire

// >>> tb/dmaam_bus_model.sv
// Far-side bus model: grants mastership after a lag and answers reads
`timescale 1ns/1ps
`default_nettype none
module dmaam_bus_model #(
	parameter int GRANT_LAG = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus from the engine
	input wire logic bus_br,
	input wire logic bus_rw,
	input wire logic [31:0] bus_addr,
	// Answers to the engine
	output logic bus_bg,
	output logic [31:0] bus_rdata
);
	logic [3:0] lag_r;

	// The core finishes its own cycle first, so the grant comes late
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lag_r <= 4'h0;
		else if (!bus_br)
			lag_r <= 4'h0;
		else if (lag_r != 4'hf)
			lag_r <= lag_r + 4'h1;
	end

	// Grant holds while requested and drops with the request
	assign bus_bg = bus_br && (int'(lag_r) >= GRANT_LAG);
	// Self-decoding memory answers any read; otherwise the lines show the inverse
	assign bus_rdata = {~bus_addr[15:0], bus_addr[15:0] ^ 16'h3c5a} ^ {32{~bus_rw}};
endmodule // dmaam_bus_model
`default_nettype wire

// >>> tb/tb_dmaam_engine.sv
// Bench for the DMA address-mode engine: transfers, timing and refusals
`timescale 1ns/1ps
`default_nettype none
module tb_dmaam_engine;
	import dmaam_pkg::*;
	typedef struct {
		int cyc; logic [31:0] addr; logic rw; logic [1:0] siz; logic burst;
		logic [1:0] cs; logic [31:0] wd; logic [2:0] tm; logic [1:0] tt; logic br;
	} dmaam_acc_s;
	logic clk, rstn, start, done_clear, single_mode, single_rw, src_inc, dst_inc;
	logic [1:0] source_size_field, dest_size_field, alt_master, bus_tt, bus_cs;
	logic [1:0][3:0] rwaits;
	logic [1:0] rburst;
	logic [31:0] source_address_reg, dest_address_reg, bus_rdata, bus_addr, bus_wdata;
	logic [15:0] byte_count_reg, byte_count_left;
	logic bus_bg, bus_br, transfer_start_strobe, bus_rw, bus_burst, busy, done, error;
	logic [1:0] bus_siz;
	logic [2:0] bus_tm;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	dmaam_acc_s log[$];

	dmaam_engine #(.NREG(2), .BCW(16)) dmaam_engine_inst (.clk(clk), .rstn(rstn),
		.start(start), .done_clear(done_clear), .single_mode(single_mode),
		.single_rw(single_rw), .src_inc(src_inc), .dst_inc(dst_inc),
		.source_size_field(source_size_field), .dest_size_field(dest_size_field),
		.source_address_reg(source_address_reg), .dest_address_reg(dest_address_reg),
		.byte_count_reg(byte_count_reg),
		.region_base({32'h20000000, 32'hffe00000}), .region_mask({32'hffff0000, 32'hfff00000}),
		.region_port({SZ_BYTE, SZ_WORD}), .region_waits(rwaits),
		.region_burst(rburst), .alternate_master_bit(alt_master),
		.sram_base(32'h10000000), .sram_mask(32'hfff00000),
		.bus_bg(bus_bg), .bus_rdata(bus_rdata), .bus_br(bus_br),
		.transfer_start_strobe(transfer_start_strobe), .bus_addr(bus_addr), .bus_rw(bus_rw),
		.bus_siz(bus_siz), .bus_burst(bus_burst), .bus_tt(bus_tt), .bus_tm(bus_tm),
		.bus_cs(bus_cs), .bus_wdata(bus_wdata), .busy(busy), .done(done), .error(error),
		.byte_count_left(byte_count_left));

	dmaam_bus_model #(.GRANT_LAG(3)) dmaam_bus_model_inst (.clk(clk), .rstn(rstn),
		.bus_br(bus_br), .bus_rw(bus_rw), .bus_addr(bus_addr), .bus_bg(bus_bg),
		.bus_rdata(bus_rdata));

	// Clock generator
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard and a log of every access start with its attributes
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_total++;
			conclude();
		end
		else if (transfer_start_strobe === 1'b1)
			log.push_back('{cyc, bus_addr, bus_rw, bus_siz, bus_burst, bus_cs, bus_wdata,
				bus_tm, bus_tt, bus_br});
	end

	task automatic conclude();
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// One logged access against its expected attributes
	task automatic chk_acc(input int i, input logic [31:0] a, input logic rw,
		input logic [1:0] siz, input logic [1:0] cs, input logic bu, input logic [2:0] tm);
		check(log[i].addr, a);
		check(log[i].rw, rw);
		check(log[i].siz, siz);
		check(log[i].cs, cs);
		check(log[i].burst, bu);
		check(log[i].tm, tm);
		check(log[i].tt, TT_DMA);
		check(log[i].br, 1'b1);
	endtask

	// Programs the channel, starts it and waits, bounded, until it is idle again
	task automatic run(input logic sm, input logic rw, input logic [1:0] ss,
		input logic [1:0] ds, input logic [31:0] sa, input logic [31:0] da);
		int n;
		log.delete();
		single_mode = sm;
		single_rw = rw;
		source_size_field = ss;
		dest_size_field = ds;
		source_address_reg = sa;
		dest_address_reg = da;
		start = 1'b1;
		tick();
		start = 1'b0;
		n = 0;
		while (busy !== 1'b1 && error !== 1'b1 && n < 10)
		begin
			tick();
			n++;
		end
		while (busy === 1'b1 && n < 300)
		begin
			tick();
			n++;
		end
		tick();
	endtask

	// Word read from a word port, then two byte writes back to back
	task automatic sc_word_to_byte();
		run(1'b0, 1'b0, SZ_WORD, SZ_BYTE, 32'hffe00400, 32'h20000000);
		check(log.size(), 3);
		chk_acc(0, 32'hffe00400, 1'b1, SZ_WORD, 2'h1, 1'b0, TM_DUAL);
		chk_acc(1, 32'h20000000, 1'b0, SZ_BYTE, 2'h2, 1'b0, TM_DUAL);
		chk_acc(2, 32'h20000001, 1'b0, SZ_BYTE, 2'h2, 1'b0, TM_DUAL);
		check(log[1].wd[7:0], 8'h5a);
		check(log[2].wd[7:0], 8'h38);
		check(log[1].cyc - log[0].cyc, 5);
		check(log[2].cyc - log[1].cyc, 2);
		check(done, 1'b1);
		check(byte_count_left, 16'h0000);
		check(bus_br, 1'b0);
		done_clear = 1'b1;
		tick();
		done_clear = 1'b0;
		check(done, 1'b0);
	endtask

	// Word destination on a bursting byte port becomes one burst access
	task automatic sc_burst();
		run(1'b0, 1'b0, SZ_WORD, SZ_WORD, 32'hffe00400, 32'h20000000);
		check(log.size(), 2);
		chk_acc(1, 32'h20000000, 1'b0, SZ_WORD, 2'h2, 1'b1, TM_DUAL);
		check(log[1].wd[15:0], 16'h385a);
	endtask

	// Same request with bursting off and one source wait: two separate byte writes
	task automatic sc_no_burst();
		rburst = 2'h0;
		rwaits[0] = 4'h1;
		run(1'b0, 1'b0, SZ_WORD, SZ_WORD, 32'hffe00400, 32'h20000000);
		rburst = 2'h2;
		rwaits[0] = 4'h3;
		check(log.size(), 3);
		chk_acc(1, 32'h20000000, 1'b0, SZ_BYTE, 2'h2, 1'b0, TM_DUAL);
		chk_acc(2, 32'h20000001, 1'b0, SZ_BYTE, 2'h2, 1'b0, TM_DUAL);
		check(log[1].wd[7:0], 8'h5a);
		check(log[2].wd[7:0], 8'h38);
		check(log[1].cyc - log[0].cyc, 3);
	endtask

	// Region hidden from the engine: default timing and no chip-select
	task automatic sc_hidden();
		alt_master = 2'h1;
		run(1'b0, 1'b0, SZ_WORD, SZ_BYTE, 32'hffe00400, 32'h20000000);
		alt_master = 2'h0;
		check(log[0].cs, 2'h0);
		check(log[1].cyc - log[0].cyc, 2);
	endtask

	// Single address transfers in both directions
	task automatic sc_single();
		for (int d = 0; d < 2; d++)
		begin
			run(1'b1, d[0], SZ_BYTE, SZ_BYTE, 32'h20000000, 32'h00000000);
			check(log.size(), 2);
			chk_acc(0, 32'h20000000, d[0], SZ_BYTE, 2'h2, 1'b0, TM_SINGLE);
			chk_acc(1, 32'h20000001, d[0], SZ_BYTE, 2'h2, 1'b0, TM_SINGLE);
		end
	endtask

	// Source or destination in standby RAM is refused without a bus request
	task automatic sc_sram();
		run(1'b0, 1'b0, SZ_BYTE, SZ_BYTE, 32'h10000010, 32'h20000000);
		check(error, 1'b1);
		check(log.size(), 0);
		run(1'b0, 1'b0, SZ_BYTE, SZ_BYTE, 32'h20000000, 32'h10000000);
		check(error, 1'b1);
		check(log.size(), 0);
		check(bus_br, 1'b0);
	endtask

	// Main sequence
	initial
	begin
		rstn = 1'b0;
		{start, done_clear, single_mode, single_rw} = 4'h0;
		{src_inc, dst_inc} = 2'h3;
		{source_size_field, dest_size_field, alt_master} = 6'h00;
		rwaits = {4'h0, 4'h3};
		rburst = 2'h2;
		{source_address_reg, dest_address_reg} = 64'h0;
		byte_count_reg = 16'h0002;
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		sc_word_to_byte();
		sc_burst();
		sc_no_burst();
		sc_hidden();
		sc_single();
		sc_sram();
		conclude();
	end
endmodule // tb_dmaam_engine
`default_nettype wire
